// File: shared/spv_link_if.sv
// synchronised pin levels and link clock edges
`timescale 1ns/100ps
`default_nettype none
interface spv_link_if;
  logic clk_rise;
  logic clk_fall;
  logic clk_lvl;
  logic data_lvl;
  logic master_clear_pin_hv;
  logic master_clear_pin_vdd;
  logic lv_sel;
  logic alt_entry;
  modport src (output clk_rise, clk_fall, clk_lvl, data_lvl, master_clear_pin_hv, master_clear_pin_vdd, lv_sel, alt_entry);
  modport dst (input clk_rise, clk_fall, clk_lvl, data_lvl, master_clear_pin_hv, master_clear_pin_vdd, lv_sel, alt_entry);
endinterface
`default_nettype wire

// File: shared/spv_params.svh
// constants of the serial program/verify port
//
// Overview of operation
// [RULE1] programmer holds clock and data low while master clear rises to high voltage
// [RULE2] entering the mode holds other device logic in reset, pins as hi-Z inputs
// [RULE3] device reset clears the address counter to zero
// [RULE4] increment-address command advances the address counter by one
// [RULE5] load-configuration command sets the address counter to 0x2000
// [RULE6] in configuration region, increment past 0x3FFF wraps to 0x2000
// [RULE7] top address bit stays set until master clear low and re-entry
// [RULE8] 0x2000-0x200F physical, 0x2000-0x2007 usable; above 0x200F reaches user memory
// [RULE9] four ID words live at 0x2000-0x2003, low four bits recommended
// [RULE10] commands are six bits, captured on falling clock edges, LSB first
// [RULE11] data frames are 16 cycles: start bit, payload LSB first, stop bit
// [RULE12] programmer waits at least 1 us between command and data or commands
// [RULE13] data driven on rising, sampled on falling edges; LSB in cycle two
// [RULE14] oscillator gets fewer than 72 clocks while master clear is mid-level
// [RULE15] after load-configuration a 14-bit word is accepted over the 16-cycle frame
// [RULE16] low-voltage enable bit set allows entry: master clear to supply, then select pin
// [RULE17] erased low-voltage enable bit reads 1, permitting low-voltage entry
// [RULE18] programmer clears low-voltage enable bit only during high-voltage entry
// [RULE19] programming loop: load, begin programming, read back, increment
// [RULE20] after entry, accesses target user program memory until configuration selected
// [RULE21] read frame drives data pin from second rising edge until 16th rising edge
// [RULE22] data memory loads keep only the first eight payload bits
// [RULE23] unrecognised command codes change nothing
`ifndef SPV_PARAMS_SVH
`define SPV_PARAMS_SVH

`define SPV_CMD_BITS 4'h6
`define SPV_FRAME_LAST 4'hf
`define SPV_PAYLOAD_LAST 4'he
`define SPV_PC_RESET 14'h0000
`define SPV_CFG_BASE 14'h2000
`define SPV_CFG_WORDS 16
`define SPV_CFG_LVP_WORD 4'h7
`define SPV_LVP_BIT 7
`define SPV_ERASED_WORD 14'h3fff
`define SPV_DM_WORDS 64
`define SPV_DM_ERASED 8'hff

`define SPV_OP_LOAD_CFG 6'b??0000
`define SPV_OP_LOAD_PM 6'b??0010
`define SPV_OP_READ_PM 6'b??0100
`define SPV_OP_INC 6'b??0110
`define SPV_OP_ERASE_PROG 6'b001000
`define SPV_OP_PROG 6'b011000
`define SPV_OP_LOAD_DM 6'b??0011
`define SPV_OP_READ_DM 6'b??0101
`define SPV_OP_BULK_PM 6'b??1001
`define SPV_OP_BULK_DM 6'b??1011

`endif

// File: shared/spv_pkg.sv
// types and command decode of the serial program/verify port
`include "spv_params.svh"
package spv_pkg;
  typedef enum logic [1:0] {
    ST_OFF = 2'h0,
    ST_CMD = 2'h1,
    ST_DATA = 2'h3
  } spv_state_t;

  typedef enum logic [3:0] {
    CMD_NONE, CMD_LOAD_CFG, CMD_LOAD_PM, CMD_READ_PM, CMD_INC, CMD_ERASE_PROG,
    CMD_PROG, CMD_LOAD_DM, CMD_READ_DM, CMD_BULK_PM, CMD_BULK_DM
  } spv_cmd_t;

  function automatic spv_cmd_t spv_decode(input logic [5:0] code);
    casez (code)
      `SPV_OP_LOAD_CFG: return CMD_LOAD_CFG;
      `SPV_OP_LOAD_PM: return CMD_LOAD_PM;
      `SPV_OP_READ_PM: return CMD_READ_PM;
      `SPV_OP_INC: return CMD_INC;
      `SPV_OP_ERASE_PROG: return CMD_ERASE_PROG;
      `SPV_OP_PROG: return CMD_PROG;
      `SPV_OP_LOAD_DM: return CMD_LOAD_DM;
      `SPV_OP_READ_DM: return CMD_READ_DM;
      `SPV_OP_BULK_PM: return CMD_BULK_PM;
      `SPV_OP_BULK_DM: return CMD_BULK_DM;
      default: return CMD_NONE;
    endcase
  endfunction
endpackage

// File: verification/spv_port_assertions.sv
// concurrent checks on the program/verify port
`timescale 1ns/100ps
`default_nettype none
module spv_port_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // watched outputs
  input wire logic prog_data_pin_oe_n,
  input wire logic prog_mode_active,
  input wire logic core_reset_hold,
  input wire logic low_voltage_select_reserved,
  input wire logic [13:0] address_counter,
  input wire logic pm_write
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // rise 2 to rise 16 is 14 link cycles of 125 ns, 350 clocks; one clock of slack
  sequence s_drive_window;
    !prog_data_pin_oe_n throughout ##[348:349] 1'b1;
  endsequence
  sequence s_release;
    ##[0:2] prog_data_pin_oe_n;
  endsequence
  ////////////////////////////////////////
  a_reset_state: assert property ($rose(reset_n) |->
    address_counter == 14'h0000 && low_voltage_select_reserved)
    else $error("state after reset wrong");
  a_entry_addr: assert property ($rose(prog_mode_active) |-> address_counter == 14'h0000)
    else $error("entry address not zero");
  a_hold_mode: assert property (core_reset_hold == prog_mode_active)
    else $error("core hold differs from mode");
  a_idle_hiz: assert property (!prog_mode_active |-> prog_data_pin_oe_n)
    else $error("data pin driven outside mode");
  a_cfg_sticky: assert property (prog_mode_active && address_counter[13] |=>
    address_counter[13] || !prog_mode_active)
    else $error("left configuration region");
  a_addr_step: assert property (prog_mode_active ##1 (prog_mode_active && $changed(address_counter)) |->
    address_counter == 14'h2000 ||
    address_counter == ((($past(address_counter) + 14'h1) & 14'h1fff) | ($past(address_counter) & 14'h2000)))
    else $error("address counter jump");
  a_user_write: assert property (pm_write |->
    prog_mode_active && !(address_counter[13] && address_counter[12:4] == 9'h0))
    else $error("user write in configuration space");
  a_read_window: assert property ($fell(prog_data_pin_oe_n) |-> s_drive_window ##1 s_release)
    else $error("read drive window wrong");
endmodule
bind spv_port spv_port_assertions u_chk (.clk(clk), .reset_n(reset_n), .prog_data_pin_oe_n(prog_data_pin_oe_n),
  .prog_mode_active(prog_mode_active), .core_reset_hold(core_reset_hold),
  .low_voltage_select_reserved(low_voltage_select_reserved), .address_counter(address_counter), .pm_write(pm_write));
`default_nettype wire

// File: verification/spv_prog_model.sv
// behavioural device programmer on the link clock and data pins
`timescale 1ns/100ps
`default_nettype none
module spv_prog_model (
  // device side of the data pin
  input wire logic dev_out,
  input wire logic dev_oe_n,
  // pins toward the device
  output logic prog_clock_pin,
  output logic prog_data_pin
);
  localparam realtime HALF = 62.5;
  logic drv_en = 1'b1;
  logic drv_val = 1'b0;
  logic [13:0] word;
  event done;
  initial prog_clock_pin = 1'b0; // clock stays low outside frames, low at entry
  // released line shows the inverse of its last level, so a stale bit cannot pass
  assign prog_data_pin = !dev_oe_n ? dev_out : (drv_en ? drv_val : !drv_val);
  ////////////////////////////////////////
  // drive after the rise, device latches at the fall
  task automatic cycle(input logic b);
    prog_clock_pin = 1'b1;
    drv_val = b;
    #HALF;
    prog_clock_pin = 1'b0;
    #HALF;
  endtask
  // six bits lsb first, then the decode gap
  task automatic cmd(input logic [5:0] c);
    for (int i = 0; i < 6; i++) cycle(c[i]);
    drv_val = 1'b0;
    #1000;
  endtask
  // start bit, payload lsb first, stop bit
  task automatic load(input logic [13:0] d);
    cycle(1'b0);
    for (int i = 0; i < 14; i++) cycle(d[i]);
    cycle(1'b0);
    #1000;
  endtask
  // sample late in the high phase of cycles 2..15
  task automatic rd_frame();
    drv_en = 1'b0;
    for (int k = 1; k <= 16; k++) begin
      prog_clock_pin = 1'b1;
      #(HALF - 10);
      if (k >= 2 && k <= 15) word[k-2] = prog_data_pin;
      #10;
      prog_clock_pin = 1'b0;
      #HALF;
    end
    -> done;
    #1000;
    drv_en = 1'b1;
  endtask
endmodule
`default_nettype wire

// File: verification/tb.sv
// self-checking bench for the program/verify port
`timescale 1ns/100ps
`default_nettype none
module tb;
  import spv_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic master_clear_pin_hv = 1'b0;
  logic master_clear_pin_vdd = 1'b0;
  logic lv_sel = 1'b0;
  logic alt = 1'b0;
  logic pclk, pdata, dout, doe_n, mode, hold, lvr, pm_write, pm_bulk;
  logic [13:0] ac, pm_wdata, pm_rdata, d;
  logic [12:0] pm_addr;
  logic [13:0] exp_q[$];
  logic [13:0] exp_a[$];
  int failures = 0;
  int num_checks = 0;
  int bulk_seen = 0;
  always #2.5 clk = ~clk;
  function automatic logic [13:0] user_word(input logic [12:0] a);
    return {1'b1, a} ^ 14'h0a5c;
  endfunction
  assign pm_rdata = user_word(pm_addr);
  spv_port uut (.clk(clk), .reset_n(reset_n), .master_clear_hv(master_clear_pin_hv), .master_clear_vdd(master_clear_pin_vdd),
    .low_voltage_select_pin(lv_sel), .alt_entry_pin(alt), .prog_clock_pin(pclk), .prog_data_pin_in(pdata),
    .prog_data_pin_out(dout), .prog_data_pin_oe_n(doe_n), .prog_mode_active(mode), .core_reset_hold(hold),
    .low_voltage_select_reserved(lvr), .address_counter(ac), .pm_addr(pm_addr), .pm_wdata(pm_wdata),
    .pm_write(pm_write), .pm_bulk_erase(pm_bulk), .pm_rdata(pm_rdata));
  spv_prog_model prog (.dev_out(dout), .dev_oe_n(doe_n), .prog_clock_pin(pclk), .prog_data_pin(pdata));
  ////////////////////////////////////////
  task automatic check(input logic [13:0] seen, input logic [13:0] expv);
    num_checks++;
    if (seen !== expv) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, expv);
    end
  endtask
  task automatic finish_test();
    if (exp_q.size() + exp_a.size() != 0) failures++;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic wait_mode(input logic v);
    for (int i = 0; i < 20 && mode !== v; i++) tick();
    if (mode !== v) begin
      failures++;
      finish_test();
    end
  endtask
  // pulses are looked at mid-cycle, where they have settled
  always @(negedge clk) begin
    if (pm_write === 1'b1) begin
      check(pm_wdata, exp_q.pop_front());
      check({1'b0, pm_addr}, exp_a.pop_front());
    end
    if (pm_bulk === 1'b1) bulk_seen++;
  end
  always @(prog.done) check(prog.word, exp_q.pop_front());
  ////////////////////////////////////////
  initial begin
    void'($urandom(32'hfe52fadc));
    repeat (8) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (4) tick();
    check(ac, 14'h0000);
    check({13'h0, lvr}, 14'h0001);
    $display("test reset done");
    master_clear_pin_vdd = 1'b1;
    tick();
    lv_sel = 1'b1;
    wait_mode(1'b1);
    master_clear_pin_vdd = 1'b0;
    lv_sel = 1'b0;
    wait_mode(1'b0);
    $display("test low-voltage entry done");
    // straight to high voltage, no mid-level time for the oscillator
    master_clear_pin_hv = 1'b1;
    wait_mode(1'b1);
    check({13'h0, hold}, 14'h0001);
    exp_q.push_back(user_word(13'h0000));
    prog.cmd(6'h04);
    prog.rd_frame();
    // don't-care upper bits set on one increment; two codes nobody decodes
    prog.cmd(6'h06);
    prog.cmd(6'h36);
    prog.cmd(6'h07);
    prog.cmd(6'h38);
    prog.cmd(6'h06);
    check(ac, 14'h0003);
    d = 14'($urandom);
    exp_q.push_back(d);
    exp_a.push_back(14'h0003);
    prog.cmd(6'h02);
    prog.load(d);
    prog.cmd(6'h08);
    exp_q.push_back(user_word(13'h0003));
    prog.cmd(6'h04);
    prog.rd_frame();
    $display("test user region done");
    d = 14'($urandom) | 14'h3ff0;
    prog.cmd(6'h00);
    check(ac, 14'h2000);
    prog.load(d);
    prog.cmd(6'h18);
    exp_q.push_back(d);
    prog.cmd(6'h04);
    prog.rd_frame();
    for (int i = 0; i < 7; i++) prog.cmd(6'h06);
    check(ac, 14'h2007);
    prog.cmd(6'h02);
    prog.load(14'h3f7f);
    prog.cmd(6'h08);
    check({13'h0, lvr}, 14'h0000);
    for (int i = 0; i < 9; i++) prog.cmd(6'h06);
    d = 14'($urandom);
    exp_q.push_back(d);
    exp_a.push_back(14'h0010);
    prog.cmd(6'h02);
    prog.load(d);
    prog.cmd(6'h18);
    $display("test configuration region done");
    master_clear_pin_hv = 1'b0;
    wait_mode(1'b0);
    master_clear_pin_vdd = 1'b1;
    tick();
    lv_sel = 1'b1;
    repeat (10) tick();
    check({13'h0, mode}, 14'h0000);
    // alternate entry pin is not gated by the low-voltage enable bit
    alt = 1'b1;
    wait_mode(1'b1);
    check(ac, 14'h0000);
    d = 14'($urandom);
    exp_q.push_back({6'h00, d[7:0]});
    prog.cmd(6'h03);
    prog.load(d);
    prog.cmd(6'h18);
    prog.cmd(6'h05);
    prog.rd_frame();
    exp_q.push_back(14'h00ff);
    prog.cmd(6'h0b);
    prog.cmd(6'h18);
    prog.cmd(6'h05);
    prog.rd_frame();
    // bulk pending turns the loaded word into an erase pulse, no write
    prog.cmd(6'h02);
    prog.load(14'h3fff);
    prog.cmd(6'h09);
    prog.cmd(6'h08);
    check(14'(bulk_seen), 14'h0001);
    $display("test data memory and bulk erase done");
    master_clear_pin_vdd = 1'b0;
    lv_sel = 1'b0;
    alt = 1'b0;
    wait_mode(1'b0);
    tick();
    master_clear_pin_hv = 1'b1;
    wait_mode(1'b1);
    check(ac, 14'h0000);
    $display("test re-entry done");
    prog.cmd(6'h00);
    check(ac, 14'h2000);
    reset_n = 1'b0;
    repeat (3) tick();
    reset_n = 1'b1;
    repeat (4) tick();
    check(ac, 14'h0000);
    check({13'h0, lvr}, 14'h0001);
    $display("test reset in mid-run done");
    repeat (4) tick();
    finish_test();
  end
endmodule
`default_nettype wire

// File: verilog/spv_pin_sync.sv
// two-flop synchronisers for all pins and edge finder for the link clock
`timescale 1ns/100ps
`default_nettype none
module spv_pin_sync
  import spv_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // raw pins: {alt, select, vdd, hv, data, clock}
  input wire logic [5:0] pins_raw,
  // synchronised view
  spv_link_if.src link
);
  logic [5:0] meta_q;
  logic [5:0] sync_q;
  logic [5:0] meta_d;
  logic [5:0] sync_d;
  logic clk_prev_q;
  logic clk_prev_d;

  genvar i;
  generate
    for (i = 0; i < 6; i++) begin : g_sync
      always_comb begin
        meta_d[i] = pins_raw[i];
        sync_d[i] = meta_q[i];
      end
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          meta_q[i] <= 1'b0;
          sync_q[i] <= 1'b0;
        end else begin
          meta_q[i] <= meta_d[i];
          sync_q[i] <= sync_d[i];
        end
      end
    end
  endgenerate

  // edge finder looks only at the second stage
  always_comb begin
    clk_prev_d = sync_q[0];
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clk_prev_q <= 1'b0;
    end else begin
      clk_prev_q <= clk_prev_d;
    end
  end

  assign link.clk_lvl = sync_q[0];
  assign link.data_lvl = sync_q[1];
  assign link.master_clear_pin_hv = sync_q[2];
  assign link.master_clear_pin_vdd = sync_q[3];
  assign link.lv_sel = sync_q[4];
  assign link.alt_entry = sync_q[5];
  assign link.clk_rise = sync_q[0] & ~clk_prev_q;
  assign link.clk_fall = ~sync_q[0] & clk_prev_q;
endmodule
`default_nettype wire

// File: verilog/spv_port.sv
// serial program/verify port: entry, command/data framing, address counter, config and data store
`timescale 1ns/100ps
`default_nettype none
`include "spv_params.svh"
module spv_port
  import spv_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // entry pins
  input wire logic master_clear_hv,
  input wire logic master_clear_vdd,
  input wire logic low_voltage_select_pin,
  input wire logic alt_entry_pin,
  // serial link
  input wire logic prog_clock_pin,
  input wire logic prog_data_pin_in,
  output logic prog_data_pin_out,
  output logic prog_data_pin_oe_n,
  // device status
  output logic prog_mode_active,
  output logic core_reset_hold,
  output logic low_voltage_select_reserved,
  output logic [13:0] address_counter,
  // user program memory
  output logic [12:0] pm_addr,
  output logic [13:0] pm_wdata,
  output logic pm_write,
  output logic pm_bulk_erase,
  input wire logic [13:0] pm_rdata
);
  spv_link_if link ();

  spv_pin_sync u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .pins_raw({alt_entry_pin, low_voltage_select_pin, master_clear_vdd, master_clear_hv,
               prog_data_pin_in, prog_clock_pin}),
    .link(link)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state

  spv_state_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [5:0] cmd_q, cmd_d;
  logic [13:0] pc_q, pc_d;
  logic [13:0] ld_q, ld_d;
  logic [13:0] rd_q, rd_d;
  logic ld_ok_q, ld_ok_d;
  logic ld_dm_q, ld_dm_d;
  logic is_read_q, is_read_d;
  logic bulk_pm_q, bulk_pm_d;
  logic bulk_dm_q, bulk_dm_d;
  logic hv_prev_q, hv_prev_d;
  logic lv_prev_q, lv_prev_d;
  logic alt_prev_q, alt_prev_d;
  logic dout_q, dout_d;
  logic oe_n_q, oe_n_d;
  logic [13:0] wdata_q, wdata_d;
  logic write_q, write_d;
  logic bulk_q, bulk_d;
  logic [13:0] cfg_q [`SPV_CFG_WORDS];
  logic [13:0] cfg_d [`SPV_CFG_WORDS];
  logic [7:0] dm_q [`SPV_DM_WORDS];
  logic [7:0] dm_d [`SPV_DM_WORDS];

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  logic lvp_en;
  logic in_cfg_phys;
  logic entry_hv;
  logic entry_lv;
  logic leave;
  logic [3:0] bit_idx;
  spv_cmd_t cmd_kind;

  assign lvp_en = cfg_q[`SPV_CFG_LVP_WORD][`SPV_LVP_BIT]; // [RULE16]
  // only the first sixteen config words exist; higher ones alias user memory
  assign in_cfg_phys = pc_q[13] && (pc_q[12:4] == 9'h000); // [RULE8]
  assign entry_hv = link.master_clear_pin_hv && !hv_prev_q && !link.clk_lvl && !link.data_lvl;
  assign entry_lv = link.master_clear_pin_vdd && ((lvp_en && link.lv_sel && !lv_prev_q) // [RULE16]
                    || (link.alt_entry && !alt_prev_q));
  assign leave = !link.master_clear_pin_vdd && !link.master_clear_pin_hv;
  assign bit_idx = cnt_q - 4'h1;
  assign cmd_kind = spv_decode({link.data_lvl, cmd_q[4:0]});

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    cmd_d = cmd_q;
    pc_d = pc_q;
    ld_d = ld_q;
    rd_d = rd_q;
    ld_ok_d = ld_ok_q;
    ld_dm_d = ld_dm_q;
    is_read_d = is_read_q;
    bulk_pm_d = bulk_pm_q;
    bulk_dm_d = bulk_dm_q;
    hv_prev_d = link.master_clear_pin_hv;
    lv_prev_d = link.lv_sel;
    alt_prev_d = link.alt_entry;
    dout_d = dout_q;
    oe_n_d = oe_n_q;
    wdata_d = wdata_q;
    write_d = 1'b0;
    bulk_d = 1'b0;
    cfg_d = cfg_q;
    dm_d = dm_q;
    if (st_q == ST_OFF) begin
      oe_n_d = 1'b1;
      if (entry_hv || entry_lv) begin
        st_d = ST_CMD;
        cnt_d = 4'h0;
        cmd_d = 6'h00;
        pc_d = `SPV_PC_RESET; // [RULE3] [RULE20]
        ld_ok_d = 1'b0;
        bulk_pm_d = 1'b0;
        bulk_dm_d = 1'b0;
      end
    end else if (leave) begin
      // only a master clear drop leaves the config region
      st_d = ST_OFF; // [RULE7]
      oe_n_d = 1'b1;
      pc_d = `SPV_PC_RESET; // [RULE3]
    end else begin
      unique case (st_q)
        ST_CMD: begin
          if (link.clk_fall) begin
            cmd_d[cnt_q[2:0]] = link.data_lvl; // [RULE10]
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == `SPV_CMD_BITS - 4'h1) begin
              cnt_d = 4'h0;
              is_read_d = 1'b0;
              unique case (cmd_kind)
                CMD_LOAD_CFG: begin
                  pc_d = `SPV_CFG_BASE; // [RULE5] [RULE15]
                  ld_dm_d = 1'b0;
                  st_d = ST_DATA;
                end
                CMD_LOAD_PM: begin
                  ld_dm_d = 1'b0;
                  st_d = ST_DATA;
                end
                CMD_LOAD_DM: begin
                  ld_dm_d = 1'b1;
                  st_d = ST_DATA;
                end
                CMD_READ_PM: begin
                  rd_d = in_cfg_phys ? cfg_q[pc_q[3:0]] : pm_rdata;
                  is_read_d = 1'b1;
                  st_d = ST_DATA;
                end
                CMD_READ_DM: begin
                  rd_d = {6'h00, dm_q[pc_q[5:0]]};
                  is_read_d = 1'b1;
                  st_d = ST_DATA;
                end
                CMD_INC: begin
                  // sticky top bit turns the low-bit carry into the config wrap
                  pc_d = {pc_q[13], pc_q[12:0] + 13'h0001}; // [RULE4] [RULE6] [RULE7]
                end
                CMD_ERASE_PROG, CMD_PROG: begin
                  if (ld_ok_q) begin
                    if (ld_dm_q) begin
                      dm_d[pc_q[5:0]] = ld_q[7:0]; // [RULE22]
                    end else if (in_cfg_phys) begin
                      cfg_d[pc_q[3:0]] = ld_q; // [RULE8] [RULE9]
                    end else begin
                      wdata_d = ld_q;
                      write_d = !bulk_pm_q;
                    end
                  end
                  if (bulk_pm_q) begin
                    bulk_d = 1'b1;
                    if (in_cfg_phys) begin
                      // the configuration word itself survives a bulk erase
                      for (int k = 0; k < `SPV_CFG_WORDS; k++) begin
                        if (k != int'(`SPV_CFG_LVP_WORD)) begin
                          cfg_d[k] = `SPV_ERASED_WORD;
                        end
                      end
                    end
                  end
                  if (bulk_dm_q) begin
                    for (int k = 0; k < `SPV_DM_WORDS; k++) begin
                      dm_d[k] = `SPV_DM_ERASED;
                    end
                  end
                  bulk_pm_d = 1'b0;
                  bulk_dm_d = 1'b0;
                  ld_ok_d = 1'b0;
                end
                CMD_BULK_PM: bulk_pm_d = 1'b1;
                CMD_BULK_DM: bulk_dm_d = 1'b1;
                CMD_NONE: begin
                end // [RULE23]
              endcase
            end
          end
        end
        ST_DATA: begin
          if (link.clk_rise && is_read_q) begin
            if (cnt_q == `SPV_FRAME_LAST) begin
              oe_n_d = 1'b1; // [RULE21]
            end else if (cnt_q != 4'h0) begin
              oe_n_d = 1'b0; // [RULE21]
              dout_d = (cnt_q <= `SPV_PAYLOAD_LAST) ? rd_q[bit_idx] : 1'b0; // [RULE13]
            end
          end
          if (link.clk_fall) begin
            cnt_d = cnt_q + 4'h1; // [RULE11]
            if (!is_read_q && cnt_q != 4'h0 && cnt_q <= `SPV_PAYLOAD_LAST) begin
              ld_d[bit_idx] = link.data_lvl; // [RULE13] [RULE15]
            end
            if (cnt_q == `SPV_FRAME_LAST) begin
              // frame only completes after all sixteen cycles, data memory too
              st_d = ST_CMD; // [RULE22]
              cnt_d = 4'h0;
              oe_n_d = 1'b1;
              ld_ok_d = ld_ok_q | !is_read_q;
            end
          end
        end
        default: st_d = ST_OFF;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= ST_OFF;
      cnt_q <= 4'h0;
      cmd_q <= 6'h00;
      pc_q <= `SPV_PC_RESET;
      ld_q <= 14'h0000;
      rd_q <= 14'h0000;
      ld_ok_q <= 1'b0;
      ld_dm_q <= 1'b0;
      is_read_q <= 1'b0;
      bulk_pm_q <= 1'b0;
      bulk_dm_q <= 1'b0;
      hv_prev_q <= 1'b0;
      lv_prev_q <= 1'b0;
      alt_prev_q <= 1'b0;
      dout_q <= 1'b0;
      oe_n_q <= 1'b1;
      wdata_q <= 14'h0000;
      write_q <= 1'b0;
      bulk_q <= 1'b0;
      for (int k = 0; k < `SPV_CFG_WORDS; k++) begin
        cfg_q[k] <= `SPV_ERASED_WORD; // [RULE17]
      end
      for (int k = 0; k < `SPV_DM_WORDS; k++) begin
        dm_q[k] <= `SPV_DM_ERASED;
      end
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      cmd_q <= cmd_d;
      pc_q <= pc_d;
      ld_q <= ld_d;
      rd_q <= rd_d;
      ld_ok_q <= ld_ok_d;
      ld_dm_q <= ld_dm_d;
      is_read_q <= is_read_d;
      bulk_pm_q <= bulk_pm_d;
      bulk_dm_q <= bulk_dm_d;
      hv_prev_q <= hv_prev_d;
      lv_prev_q <= lv_prev_d;
      alt_prev_q <= alt_prev_d;
      dout_q <= dout_d;
      oe_n_q <= oe_n_d;
      wdata_q <= wdata_d;
      write_q <= write_d;
      bulk_q <= bulk_d;
      cfg_q <= cfg_d;
      dm_q <= dm_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prog_mode_active = (st_q != ST_OFF);
  assign core_reset_hold = (st_q != ST_OFF); // [RULE2]
  assign low_voltage_select_reserved = lvp_en; // [RULE16]
  assign address_counter = pc_q;
  assign pm_addr = pc_q[12:0];
  assign pm_wdata = wdata_q;
  assign pm_write = write_q;
  assign pm_bulk_erase = bulk_q;
  assign prog_data_pin_out = dout_q;
  assign prog_data_pin_oe_n = oe_n_q;
endmodule
`default_nettype wire
